// ---- pkg/ssx_cfg.svh ----
// Constants for the subtract/swap/xor datapath
`ifndef SSX_CFG_SVH
`define SSX_CFG_SVH
`define SSX_ADR_CTRL    8'h00
`define SSX_ADR_OPER    8'h04
`define SSX_ADR_ACC     8'h08
`define SSX_ADR_FILE    8'h0C
`define SSX_ADR_STAT    8'h10
`define SSX_ADR_LAST    8'h10
`define SSX_FB_CARRY    0
`define SSX_FB_NIBC     1
`define SSX_FB_ZERO     2
`define SSX_FB_BUSY     3
`define SSX_OB_OP_LO    0
`define SSX_OB_OP_HI    1
`define SSX_OB_DEST     2
`define SSX_OB_ADR_LO   8
`define SSX_OB_ADR_HI   14
`define SSX_OB_LIT_LO   16
`define SSX_OB_LIT_HI   23
`define SSX_CB_GO       0
`define SSX_RST_BYTE    8'h00
`define SSX_RST_OPER    24'h00_0000
`define SSX_FILE_DEPTH  128
`endif

// ---- pkg/ssx_pkg.sv ----
// Types for the subtract/swap/xor datapath
package ssx_pkg;
	typedef enum logic [1:0] {
		SSX_SUB_ACC_FROM_FILE   = 2'h0,
		SSX_NIBBLE_EXCHANGE_OP  = 2'h1,
		SSX_XOR_LITERAL_INTO_ACC = 2'h2,
		SSX_XOR_ACC_WITH_FILE   = 2'h3
	} ssx_op_t;
	typedef enum logic [1:0] {
		SSX_IDLE  = 2'b00,
		SSX_FETCH = 2'b01,
		SSX_EXEC  = 2'b11
	} ssx_state_t;
endpackage

// ---- pkg/ssx_alu_if.sv ----
// Carrier between sequencer and arithmetic unit
`timescale 1ns/10ps
interface ssx_alu_if;
	import ssx_pkg::*;
	ssx_op_t    op;
	logic [7:0] acc;
	logic [7:0] fval;
	logic [7:0] lit;
	logic [7:0] res;
	logic       carry;
	logic       nibc;
	logic       zero;
	logic       wr_c;
	logic       wr_dc;
	modport core (output op, output acc, output fval, output lit,
		input res, input carry, input nibc, input zero, input wr_c, input wr_dc);
	modport alu  (input op, input acc, input fval, input lit,
		output res, output carry, output nibc, output zero, output wr_c, output wr_dc);
endinterface

// ---- core/ssx_alu.sv ----
// Combinational arithmetic for the four operations
`timescale 1ns/10ps
module ssx_alu
	import ssx_pkg::*;
(
	ssx_alu_if.alu a
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Subtraction f - w with borrow-free carries
	function automatic logic [9:0] sub_fw(input logic [7:0] f, input logic [7:0] w);
		logic [8:0] full;
		logic [4:0] low;
		full = {1'b0, f} + {1'b0, ~w} + 9'h001;
		low  = {1'b0, f[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
		sub_fw = {full[8], low[4], full[7:0]};
	endfunction
	logic [9:0] sub_w;
	assign sub_w = sub_fw(a.fval, a.acc);

	// Result and flag selection
	always_comb begin
		a.res   = a.fval;
		a.carry = sub_w[9];
		a.nibc  = sub_w[8];
		a.wr_c  = 1'b0;
		a.wr_dc = 1'b0;
		case (a.op)
			SSX_SUB_ACC_FROM_FILE: begin
				a.res   = sub_w[7:0];
				a.wr_c  = 1'b1;
				a.wr_dc = 1'b1;
			end
			SSX_NIBBLE_EXCHANGE_OP: begin
				a.res = {a.fval[3:0], a.fval[7:4]};
			end
			SSX_XOR_LITERAL_INTO_ACC: begin
				a.res = a.acc ^ a.lit;
			end
			SSX_XOR_ACC_WITH_FILE: begin
				a.res = a.acc ^ a.fval;
			end
			default: begin
				a.res = a.fval;
			end
		endcase
	end
	assign a.zero = (a.res == 8'h00);
endmodule

// ---- core/ssx_core.sv ----
// Subtract/swap/xor execution datapath with Wishbone register slave
// Functional notes
// - Subtract computes file minus accumulator
// - Destination bit picks accumulator or file
// - Subtract updates carry, nibble carry, zero
// - Swap exchanges file register nibbles
// - Swap leaves every flag unchanged
// - Swap result routed by destination bit
// - Literal xor writes accumulator only
// - File xor routed by destination bit
// - Both xors update zero only
// - Seven-bit file address plus destination bit
//
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "ssx_cfg.svh"
module ssx_core
	import ssx_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	output logic             err_o,
	output logic             busy_o
);
	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [7:0]  file_mem [0:`SSX_FILE_DEPTH-1];
	logic [7:0]  acc_r;
	logic [23:0] oper_r;
	logic        carry_r;
	logic        nibc_r;
	logic        zero_r;
	logic [7:0]  fval_r;
	ssx_state_t  state_r;
	logic        ack_r;
	logic        err_r;
	logic [31:0] dat_r;

	// Operand fields
	ssx_op_t     op_w;
	logic        dest_w;
	logic [6:0]  fadr_w;
	logic [7:0]  lit_w;
	// seven-bit address and one destination bit
	assign op_w   = ssx_op_t'(oper_r[`SSX_OB_OP_HI:`SSX_OB_OP_LO]);
	assign dest_w = oper_r[`SSX_OB_DEST];
	assign fadr_w = oper_r[`SSX_OB_ADR_HI:`SSX_OB_ADR_LO];
	assign lit_w  = oper_r[`SSX_OB_LIT_HI:`SSX_OB_LIT_LO];

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic req_w;
	logic wr_w;
	logic hit_w;
	logic go_w;
	logic idle_w;
	assign req_w  = cyc_i && stb_i && !ack_r && !err_r;
	assign hit_w  = (adr_i[1:0] == 2'b00) && (adr_i <= `SSX_ADR_LAST);
	assign wr_w   = req_w && hit_w && we_i;
	assign idle_w = (state_r == SSX_IDLE);
	assign go_w   = wr_w && sel_i[0] && (adr_i == `SSX_ADR_CTRL)
		&& dat_i[`SSX_CB_GO] && idle_w;

	// Byte-lane merge for an 8-bit register in lane 0
	function automatic logic [7:0] lane0(input logic [7:0] old, input logic [3:0] sel,
		input logic [31:0] d);
		lane0 = sel[0] ? d[7:0] : old;
	endfunction

	// ----------------------------------------
	// Arithmetic unit
	// ----------------------------------------
	ssx_alu_if alu_bus ();
	assign alu_bus.op   = op_w;
	assign alu_bus.acc  = acc_r;
	assign alu_bus.fval = fval_r;
	assign alu_bus.lit  = lit_w;
	ssx_alu u_alu (
		.a (alu_bus.alu)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// Fetch reads the file register a cycle ahead of the operation
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= SSX_IDLE;
		end else begin
			case (state_r)
				SSX_IDLE:  state_r <= go_w ? SSX_FETCH : SSX_IDLE;
				SSX_FETCH: state_r <= SSX_EXEC;
				SSX_EXEC:  state_r <= SSX_IDLE;
				default:   state_r <= SSX_IDLE;
			endcase
		end
	end

	// File operand latch
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fval_r <= `SSX_RST_BYTE;
		end else if (state_r == SSX_FETCH) begin
			fval_r <= file_mem[fadr_w];
		end
	end

	logic exec_w;
	logic to_file_w;
	assign exec_w = (state_r == SSX_EXEC);
	// result to file only when destination is one
	// literal xor never writes the file
	assign to_file_w = exec_w && dest_w && (op_w != SSX_XOR_LITERAL_INTO_ACC);

	// ----------------------------------------
	// Accumulator
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc_r <= `SSX_RST_BYTE;
		end else if (exec_w && !to_file_w) begin
			acc_r <= alu_bus.res;
		end else if (wr_w && idle_w && adr_i == `SSX_ADR_ACC) begin
			acc_r <= lane0(acc_r, sel_i, dat_i);
		end
	end

	// ----------------------------------------
	// File registers
	// ----------------------------------------
	// Software writes the file through a window addressed by the operand address
	always_ff @(posedge clk_i) begin
		if (to_file_w) begin
			file_mem[fadr_w] <= alu_bus.res;
		end else if (wr_w && idle_w && sel_i[0] && adr_i == `SSX_ADR_FILE) begin
			file_mem[fadr_w] <= dat_i[7:0];
		end
	end

	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	// subtract loads carry and nibble carry
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			carry_r <= 1'b0;
			nibc_r  <= 1'b0;
		end else if (exec_w && alu_bus.wr_c) begin
			carry_r <= alu_bus.carry;
			nibc_r  <= alu_bus.nibc;
		end else if (wr_w && idle_w && sel_i[0] && adr_i == `SSX_ADR_STAT) begin
			carry_r <= dat_i[`SSX_FB_CARRY];
			nibc_r  <= dat_i[`SSX_FB_NIBC];
		end
	end

	// xor and subtract load zero; swap does not
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			zero_r <= 1'b0;
		end else if (exec_w && op_w != SSX_NIBBLE_EXCHANGE_OP) begin
			zero_r <= alu_bus.zero;
		end else if (wr_w && idle_w && sel_i[0] && adr_i == `SSX_ADR_STAT) begin
			zero_r <= dat_i[`SSX_FB_ZERO];
		end
	end

	// ----------------------------------------
	// Operand register
	// ----------------------------------------
	// Writes are refused while an operation runs so the fields stay stable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			oper_r <= `SSX_RST_OPER;
		end else if (wr_w && idle_w && adr_i == `SSX_ADR_OPER) begin
			if (sel_i[0]) oper_r[7:0]   <= dat_i[7:0];
			if (sel_i[1]) oper_r[15:8]  <= dat_i[15:8];
			if (sel_i[2]) oper_r[23:16] <= dat_i[23:16];
		end
	end

	// ----------------------------------------
	// Bus answer
	// ----------------------------------------
	// One-cycle registered ack; unmapped addresses answer err
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			err_r <= 1'b0;
		end else begin
			ack_r <= req_w && hit_w;
			err_r <= req_w && !hit_w;
		end
	end

	// Read data
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_r <= 32'h0000_0000;
		end else if (req_w && !we_i) begin
			case (adr_i)
				`SSX_ADR_CTRL: dat_r <= {31'h0000_0000, !idle_w};
				`SSX_ADR_OPER: dat_r <= {8'h00, oper_r};
				`SSX_ADR_ACC:  dat_r <= {24'h00_0000, acc_r};
				`SSX_ADR_FILE: dat_r <= {24'h00_0000, file_mem[fadr_w]};
				`SSX_ADR_STAT: dat_r <= {28'h000_0000, !idle_w, zero_r, nibc_r, carry_r};
				default:       dat_r <= 32'h0000_0000;
			endcase
		end
	end

	assign dat_o  = dat_r;
	assign ack_o  = ack_r;
	assign err_o  = err_r;
	assign busy_o = !idle_w;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_start;
		go_w;
	endsequence
	sequence s_done;
		##2 exec_w;
	endsequence

	property p_sub_result;
		@(posedge clk_i) disable iff (rst_i)
		exec_w && op_w == SSX_SUB_ACC_FROM_FILE && !dest_w
		|=> acc_r == 8'($past(fval_r) - $past(acc_r));
	endproperty
	a_sub_result: assert property (p_sub_result) else $error("subtract result wrong");

	property p_dest_file;
		@(posedge clk_i) disable iff (rst_i)
		exec_w && dest_w && op_w != SSX_XOR_LITERAL_INTO_ACC |=> $stable(acc_r);
	endproperty
	a_dest_file: assert property (p_dest_file) else $error("accumulator hit on file dest");

	property p_sub_carry;
		@(posedge clk_i) disable iff (rst_i)
		exec_w && op_w == SSX_SUB_ACC_FROM_FILE
		|=> carry_r == ($past(fval_r) >= $past(acc_r));
	endproperty
	a_sub_carry: assert property (p_sub_carry) else $error("subtract carry wrong");

	property p_swap_val;
		@(posedge clk_i) disable iff (rst_i)
		exec_w && op_w == SSX_NIBBLE_EXCHANGE_OP && !dest_w
		|=> acc_r == {$past(fval_r[3:0]), $past(fval_r[7:4])};
	endproperty
	a_swap_val: assert property (p_swap_val) else $error("swap result wrong");

	property p_swap_flags;
		@(posedge clk_i) disable iff (rst_i)
		exec_w && op_w == SSX_NIBBLE_EXCHANGE_OP
		|=> $stable(carry_r) && $stable(nibc_r) && $stable(zero_r);
	endproperty
	a_swap_flags: assert property (p_swap_flags) else $error("swap changed a flag");

	property p_swap_file;
		@(posedge clk_i) disable iff (rst_i)
		exec_w && op_w == SSX_NIBBLE_EXCHANGE_OP && dest_w
		|=> file_mem[$past(fadr_w)] == {$past(fval_r[3:0]), $past(fval_r[7:4])};
	endproperty
	a_swap_file: assert property (p_swap_file) else $error("swap file write wrong");

	property p_xlit;
		@(posedge clk_i) disable iff (rst_i)
		exec_w && op_w == SSX_XOR_LITERAL_INTO_ACC
		|=> acc_r == ($past(acc_r) ^ $past(lit_w));
	endproperty
	a_xlit: assert property (p_xlit) else $error("literal xor wrong");

	property p_xor_flags;
		@(posedge clk_i) disable iff (rst_i)
		exec_w && (op_w == SSX_XOR_ACC_WITH_FILE || op_w == SSX_XOR_LITERAL_INTO_ACC)
		|=> $stable(carry_r) && $stable(nibc_r);
	endproperty
	a_xor_flags: assert property (p_xor_flags) else $error("xor changed carry");

	property p_zero;
		@(posedge clk_i) disable iff (rst_i)
		exec_w && op_w != SSX_NIBBLE_EXCHANGE_OP |=> zero_r == ($past(alu_bus.res) == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");

	property p_sub_nibc;
		@(posedge clk_i) disable iff (rst_i)
		exec_w && op_w == SSX_SUB_ACC_FROM_FILE
		|=> nibc_r == ($past(fval_r[3:0]) >= $past(acc_r[3:0]));
	endproperty
	a_sub_nibc: assert property (p_sub_nibc) else $error("nibble carry wrong");

	property p_sub_file;
		@(posedge clk_i) disable iff (rst_i)
		exec_w && op_w == SSX_SUB_ACC_FROM_FILE && dest_w
		|=> file_mem[$past(fadr_w)] == 8'($past(fval_r) - $past(acc_r));
	endproperty
	a_sub_file: assert property (p_sub_file) else $error("subtract file write wrong");

	property p_xfile_acc;
		@(posedge clk_i) disable iff (rst_i)
		exec_w && op_w == SSX_XOR_ACC_WITH_FILE && !dest_w
		|=> acc_r == ($past(acc_r) ^ $past(fval_r));
	endproperty
	a_xfile_acc: assert property (p_xfile_acc) else $error("file xor to acc wrong");

	property p_xfile_mem;
		@(posedge clk_i) disable iff (rst_i)
		exec_w && op_w == SSX_XOR_ACC_WITH_FILE && dest_w
		|=> file_mem[$past(fadr_w)] == ($past(acc_r) ^ $past(fval_r));
	endproperty
	a_xfile_mem: assert property (p_xfile_mem) else $error("file xor to file wrong");

	property p_xlit_keep;
		@(posedge clk_i) disable iff (rst_i)
		exec_w && op_w == SSX_XOR_LITERAL_INTO_ACC
		|=> file_mem[$past(fadr_w)] == $past(fval_r);
	endproperty
	a_xlit_keep: assert property (p_xlit_keep) else $error("literal xor wrote file");

	property p_xlit_zero;
		@(posedge clk_i) disable iff (rst_i)
		exec_w && op_w == SSX_XOR_LITERAL_INTO_ACC
		|=> zero_r == (($past(acc_r) ^ $past(lit_w)) == 8'h00);
	endproperty
	a_xlit_zero: assert property (p_xlit_zero) else $error("literal xor zero wrong");

	property p_seq;
		@(posedge clk_i) disable iff (rst_i)
		s_start |-> s_done;
	endproperty
	a_seq: assert property (p_seq) else $error("operation did not execute in time");
endmodule

// ---- verification/subtract_swap_xor_alu_ops_test.sv ----
// Self-checking bench for the subtract/swap/xor datapath
`timescale 1ns/10ps
`include "ssx_cfg.svh"
`define CHK(got, exp, msg) begin n_tests++; if ((got) !== (exp)) begin err_count++; \
	$display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp); end end
module subtract_swap_xor_alu_ops_test;
	import ssx_pkg::*;
	logic        clk_i;
	logic        rst_i;
	logic        cyc_i;
	logic        stb_i;
	logic        we_i;
	logic [7:0]  adr_i;
	logic [3:0]  sel_i;
	logic [31:0] dat_i;
	logic [31:0] dat_o;
	logic        ack_o;
	logic        err_o;
	logic        busy_o;
	int          err_count;
	int          n_tests;
	int          cycles;
	int          busy_cnt;
	logic [31:0] q;
	logic        e;

	ssx_core dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.err_o(err_o), .busy_o(busy_o));

	// Free-running 200 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// Hang guard: the full run needs a few thousand cycles at most
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_count++;
			end_of_test();
		end
	end

	// Busy cycle count, read as a difference around each operation
	always @(posedge clk_i) begin
		if (busy_o === 1'b1) begin
			busy_cnt <= busy_cnt + 1;
		end
	end

	task automatic end_of_test();
		if (err_count == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// One classic cycle; the request stands until ack or err is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hf;
		// Only the hang guard ends a wait that never sees an answer
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1 && err_o !== 1'b1);
		rd = dat_o;
		er = err_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
		@(posedge clk_i);
	endtask

	// Loads operands, starts one operation, compares against an integer model
	task automatic run_op(input int op, input int d, input int fa, input int lit,
		input int w, input int f, input int fl);
		int r;
		int ea;
		int ef;
		int mc;
		int mdc;
		int mz;
		int i;
		int b0;
		logic [31:0] rd;
		logic er;
		mc  = fl & 1;
		mdc = (fl >> 1) & 1;
		mz  = (fl >> 2) & 1;
		ea  = w;
		ef  = f;
		wb(1'b1, `SSX_ADR_OPER, {8'h00, 8'(lit), 1'b0, 7'(fa), 5'h00, 1'(d), 2'(op)}, rd, er);
		wb(1'b1, `SSX_ADR_ACC, 32'(w), rd, er);
		wb(1'b1, `SSX_ADR_FILE, 32'(f), rd, er);
		wb(1'b1, `SSX_ADR_STAT, 32'(fl), rd, er);
		b0 = busy_cnt;
		wb(1'b1, `SSX_ADR_CTRL, 32'h0000_0001, rd, er);
		i = 0;
		do begin
			wb(1'b0, `SSX_ADR_CTRL, 32'h0000_0000, rd, er);
			i++;
		end while (rd[0] !== 1'b0 && i < 20);
		`CHK(rd[0], 1'b0, "operation never finished")
		// Fetch then execute: busy stands exactly two cycles
		`CHK(busy_cnt - b0, 2, "busy length")
		case (op)
			0: begin
				r   = (f - w) & 255;
				mc  = (f >= w);
				mdc = ((f % 16) >= (w % 16));
				mz  = (r == 0);
			end
			1: r = ((f << 4) | (f >> 4)) & 255;
			2: begin
				r  = w ^ lit;
				mz = (r == 0);
			end
			default: begin
				r  = w ^ f;
				mz = (r == 0);
			end
		endcase
		if (op != 2 && d == 1) ef = r;
		else ea = r;
		wb(1'b0, `SSX_ADR_ACC, 32'h0000_0000, rd, er);
		`CHK(rd[7:0], 8'(ea), "accumulator")
		wb(1'b0, `SSX_ADR_FILE, 32'h0000_0000, rd, er);
		`CHK(rd[7:0], 8'(ef), "file register")
		wb(1'b0, `SSX_ADR_STAT, 32'h0000_0000, rd, er);
		`CHK(rd[3:0], {1'b0, 1'(mz), 1'(mdc), 1'(mc)}, "status flags")
	endtask

	// Main sequence
	initial begin
		err_count = 0;
		n_tests   = 0;
		rst_i     = 1'b1;
		cyc_i     = 1'b0;
		stb_i     = 1'b0;
		we_i      = 1'b0;
		adr_i     = 8'h00;
		sel_i     = 4'h0;
		dat_i     = 32'h0000_0000;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		void'($urandom(32'h66e6_467b));
		// Cleared state after reset
		wb(1'b0, `SSX_ADR_ACC, 32'h0000_0000, q, e);
		`CHK(q[7:0], 8'h00, "acc after reset")
		wb(1'b0, `SSX_ADR_STAT, 32'h0000_0000, q, e);
		`CHK(q[3:0], 4'h0, "flags after reset")
		// Unmapped and misaligned addresses are refused
		wb(1'b1, 8'h14, 32'h0000_00ff, q, e);
		`CHK(e, 1'b1, "unmapped write")
		wb(1'b0, 8'h09, 32'h0000_0000, q, e);
		`CHK(e, 1'b1, "misaligned read")
		// Every operation with both destinations
		for (int op = 0; op < 4; op++) begin
			for (int d = 0; d < 2; d++) begin
				run_op(op, d, $urandom_range(127), $urandom_range(255), $urandom_range(255),
					$urandom_range(255), $urandom_range(7));
			end
		end
		// Boundaries: equal operands, borrow wrap, top address, full literal
		run_op(0, 0, 127, 0, 8'h5a, 8'h5a, 0);
		run_op(0, 1, 0, 0, 1, 0, 7);
		run_op(0, 0, 3, 0, 8'h1f, 8'h20, 2);
		run_op(2, 1, 5, 255, 8'hff, 8'h33, 3);
		run_op(3, 1, 127, 0, 8'ha5, 8'ha5, 3);
		run_op(1, 1, 64, 0, 0, 8'h00, 5);
		// Random operations across the whole file space
		for (int k = 0; k < 40; k++) begin
			run_op($urandom_range(3), $urandom_range(1), $urandom_range(127),
				$urandom_range(255), $urandom_range(255), $urandom_range(255),
				$urandom_range(7));
		end
		end_of_test();
	end
endmodule
